// file: shared/sst_pkg.sv
// constants, codes and types shared by the subtract/swap/skip/table/xor execution block
package sst_pkg;

    // ***************************************************************
    // register byte offsets
    // ***************************************************************
    localparam logic [11:0] ADDR_INSTR = 12'h000;
    localparam logic [11:0] ADDR_ACC   = 12'h004;
    localparam logic [11:0] ADDR_FLAGS = 12'h008;
    localparam logic [11:0] ADDR_TABLE_POINTER_LOW_REG  = 12'h00C;
    localparam logic [11:0] ADDR_TABLE_POINTER_HIGH_REG  = 12'h010;
    localparam logic [11:0] ADDR_TABLE_HIGH_BYTE_REG  = 12'h014;
    localparam logic [11:0] ADDR_PAGE  = 12'h018;
    localparam logic [11:0] ADDR_EXEC  = 12'h01C;
    localparam logic [1:0]  DMEM_TAG   = 2'h1;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int INSTR_OP_LSB  = 0;
    localparam int INSTR_BIT_LSB = 8;
    localparam int INSTR_ADR_LSB = 16;
    localparam int INSTR_LIT_LSB = 24;
    localparam int FLAG_C        = 0;
    localparam int FLAG_AC       = 1;
    localparam int FLAG_Z        = 2;
    localparam int FLAG_OV       = 3;
    localparam int EXEC_BUSY     = 0;
    localparam int EXEC_SKIP     = 1;
    localparam int EXEC_CYC_LSB  = 2;

    // ***************************************************************
    // reset values, responses, cycle counts
    // ***************************************************************
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [3:0] RST_FLAGS  = 4'h0;
    localparam logic [3:0] FULL_STRB  = 4'hF;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVER = 2'h2;
    localparam logic [1:0] CYC_ONE    = 2'h1;
    localparam logic [1:0] CYC_TWO    = 2'h2;

    typedef enum logic [3:0] {
        OP_SUB_MEM, OP_SUB_IMM, OP_SWAP_MEM, OP_SWAP_ACC, OP_SKIP_ZERO,
        OP_COPY_SKIP, OP_SKIP_BIT, OP_TAB_PAGED, OP_TAB_CUR, OP_TAB_LAST,
        OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM
    } sst_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TFETCH, ST_DUMMY} sst_state_t;

    typedef enum logic [3:0] {
        R_INSTR, R_ACC, R_FLAGS, R_TABLE_POINTER_LOW_REG, R_TABLE_POINTER_HIGH_REG, R_TABLE_HIGH_BYTE_REG, R_PAGE, R_EXEC, R_DMEM, R_NONE
    } sst_reg_t;

endpackage

// file: hdl/sst_sub.sv
// eight-bit subtractor with not-borrow, half not-borrow and signed overflow
module sst_sub
    import sst_pkg::*;
(
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    output logic      [7:0] diff_o,
    output logic            c_o,
    output logic            ac_o,
    output logic            ov_o
);

    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // a + ~b + 1: the carry out is the not-borrow
    assign full_sum = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
    assign low_sum  = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
    assign diff_o   = full_sum[7:0];
    assign c_o      = full_sum[8];
    assign ac_o     = low_sum[4];
    assign ov_o     = (a_i[7] ^ b_i[7]) & (a_i[7] ^ full_sum[7]);

endmodule

// file: hdl/sst_core.sv
// execution core for subtract, swap, skip, table read and xor, with AXI4-Lite registers
//
// Our own choices: the register offsets and register access over AXI4-Lite.
module sst_core
    import sst_pkg::*;
#(
    parameter int PROG_AW = 12,
    parameter int AXI_AW  = 12
) (
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    input  wire logic [AXI_AW-1:0]  s_axi_awaddr_i,
    input  wire logic               s_axi_awvalid_i,
    output logic                    s_axi_awready_o,
    input  wire logic [31:0]        s_axi_wdata_i,
    input  wire logic [3:0]         s_axi_wstrb_i,
    input  wire logic               s_axi_wvalid_i,
    output logic                    s_axi_wready_o,
    output logic [1:0]              s_axi_bresp_o,
    output logic                    s_axi_bvalid_o,
    input  wire logic               s_axi_bready_i,
    input  wire logic [AXI_AW-1:0]  s_axi_araddr_i,
    input  wire logic               s_axi_arvalid_i,
    output logic                    s_axi_arready_o,
    output logic [31:0]             s_axi_rdata_o,
    output logic [1:0]              s_axi_rresp_o,
    output logic                    s_axi_rvalid_o,
    input  wire logic               s_axi_rready_i,
    output logic [PROG_AW-1:0]      prog_addr_o,
    output logic                    prog_rd_o,
    input  wire logic [15:0]        prog_data_i,
    output logic                    busy_o,
    output logic                    skip_o
);

    localparam int PW = PROG_AW - 8;

    if (PROG_AW < 9 || PROG_AW > 16) begin : g_bad_prog_aw
        $error("PROG_AW must lie between 9 and 16");
    end
    if (AXI_AW < 12) begin : g_bad_axi_aw
        $error("AXI_AW must be at least 12");
    end

    function automatic logic is_zero(input logic [7:0] v);
        return v == RST_BYTE;
    endfunction

    function automatic sst_reg_t decode(input logic [11:0] a);
        if (a[11:10] == DMEM_TAG) begin
            return R_DMEM;
        end
        case ({a[11:2], 2'b00})
            ADDR_INSTR: return R_INSTR;
            ADDR_ACC:   return R_ACC;
            ADDR_FLAGS: return R_FLAGS;
            ADDR_TABLE_POINTER_LOW_REG:  return R_TABLE_POINTER_LOW_REG;
            ADDR_TABLE_POINTER_HIGH_REG:  return R_TABLE_POINTER_HIGH_REG;
            ADDR_TABLE_HIGH_BYTE_REG:  return R_TABLE_HIGH_BYTE_REG;
            ADDR_PAGE:  return R_PAGE;
            ADDR_EXEC:  return R_EXEC;
            default:    return R_NONE;
        endcase
    endfunction

    // ***************************************************************
    // state
    // ***************************************************************
    logic [7:0]  dmem [256];
    logic [7:0]  acc;
    logic [3:0]  flags;
    logic [7:0]  table_pointer_low_reg;
    logic [7:0]  table_pointer_high_reg;
    logic [7:0]  table_high_byte_reg;
    logic [7:0]  page;
    sst_state_t  state;
    sst_state_t  next_state;
    sst_op_t     op_q;
    logic [2:0]  bit_q;
    logic [7:0]  maddr_q;
    logic [7:0]  lit_q;
    logic        skip_q;
    logic [1:0]  cyc_q;
    logic        aw_full;
    logic        w_full;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    // ***************************************************************
    // bus write and read decode
    // ***************************************************************
    sst_reg_t    wsel;
    sst_reg_t    rsel;
    logic        wr_fire;
    logic        wr_lane0;
    logic        start;
    logic        b_done;
    logic        next_aw_full;
    logic        next_w_full;
    logic        next_r_busy;
    logic [31:0] rd_word;

    // writes wait for an idle core, so bus and execution never race on a register
    assign wsel     = decode(awaddr_q);
    assign rsel     = decode(s_axi_araddr_i[11:0]);
    assign wr_fire  = aw_full & w_full & ~s_axi_bvalid_o & (state == ST_IDLE);
    assign wr_lane0 = wr_fire & wstrb_q[0];
    // a partial write of the instruction word is dropped rather than half-merged
    assign start    = wr_fire & (wsel == R_INSTR) & (wstrb_q == FULL_STRB);
    assign b_done   = s_axi_bvalid_o & s_axi_bready_i;
    assign next_aw_full = (aw_full & ~b_done) | (s_axi_awvalid_i & s_axi_awready_o);
    assign next_w_full  = (w_full & ~b_done) | (s_axi_wvalid_i & s_axi_wready_o);
    assign next_r_busy  = (s_axi_rvalid_o & ~s_axi_rready_i) |
                          (s_axi_arvalid_i & s_axi_arready_o);

    // ***************************************************************
    // execution datapath
    // ***************************************************************
    logic        in_exec;
    logic        in_fetch;
    logic [7:0]  mem_val;
    logic [7:0]  sub_b;
    logic [7:0]  sub_res;
    logic        sub_c;
    logic        sub_ac;
    logic        sub_ov;
    logic [7:0]  xor_res;
    logic [7:0]  swap_res;
    logic        is_sub;
    logic        is_xor;
    logic        is_tab;
    logic        skip_take;
    logic [PROG_AW-1:0] tab_addr;
    logic        dmem_we;
    logic [7:0]  dmem_waddr;
    logic [7:0]  dmem_wdata;
    logic        acc_we;
    logic [7:0]  acc_wdata;

    assign in_exec  = (state == ST_EXEC);
    assign in_fetch = (state == ST_TFETCH);
    assign mem_val  = dmem[maddr_q];
    assign sub_b    = (op_q == OP_SUB_IMM) ? lit_q : mem_val;
    assign xor_res  = acc ^ ((op_q == OP_XOR_IMM) ? lit_q : mem_val);
    assign swap_res = {mem_val[3:0], mem_val[7:4]};
    assign is_sub   = (op_q == OP_SUB_MEM) | (op_q == OP_SUB_IMM);
    assign is_xor   = (op_q == OP_XOR_ACC) | (op_q == OP_XOR_MEM) | (op_q == OP_XOR_IMM);
    assign is_tab   = (op_q == OP_TAB_PAGED) | (op_q == OP_TAB_CUR) | (op_q == OP_TAB_LAST);

    sst_sub u_sub (
        .a_i    (acc),
        .b_i    (sub_b),
        .diff_o (sub_res),
        .c_o    (sub_c),
        .ac_o   (sub_ac),
        .ov_o   (sub_ov)
    );

    assign skip_take = in_exec & (
        (((op_q == OP_SKIP_ZERO) | (op_q == OP_COPY_SKIP)) & is_zero(mem_val)) |
        ((op_q == OP_SKIP_BIT) & ~mem_val[bit_q]));

    // page part of the program address picks one of three sources
    assign tab_addr = (op_q == OP_TAB_PAGED) ? {table_pointer_high_reg[PW-1:0], table_pointer_low_reg} :
                      (op_q == OP_TAB_CUR)   ? {page[PW-1:0], table_pointer_low_reg} :
                                               {{PW{1'b1}}, table_pointer_low_reg};

    // memory write sources are exclusive by state
    assign dmem_we    = (wr_lane0 & (wsel == R_DMEM)) | in_fetch |
                        (in_exec & ((op_q == OP_SUB_MEM) | (op_q == OP_SWAP_MEM) |
                                    (op_q == OP_XOR_MEM)));
    assign dmem_waddr = in_exec | in_fetch ? maddr_q : awaddr_q[9:2];
    assign dmem_wdata = in_fetch                 ? prog_data_i[7:0] :
                        ~in_exec                 ? wdata_q[7:0] :
                        (op_q == OP_SUB_MEM)     ? sub_res :
                        (op_q == OP_SWAP_MEM)    ? swap_res :
                                                   xor_res;

    assign acc_we    = (wr_lane0 & (wsel == R_ACC)) |
                       (in_exec & ((op_q == OP_SUB_IMM) | (op_q == OP_SWAP_ACC) |
                                   (op_q == OP_COPY_SKIP) | (op_q == OP_XOR_ACC) |
                                   (op_q == OP_XOR_IMM)));
    assign acc_wdata = ~in_exec                  ? wdata_q[7:0] :
                       (op_q == OP_SUB_IMM)      ? sub_res :
                       (op_q == OP_SWAP_ACC)     ? swap_res :
                       (op_q == OP_COPY_SKIP)    ? mem_val :
                                                   xor_res;

    assign rd_word = (rsel == R_ACC)   ? {24'h000000, acc} :
                     (rsel == R_FLAGS) ? {28'h0000000, flags} :
                     (rsel == R_TABLE_POINTER_LOW_REG)  ? {24'h000000, table_pointer_low_reg} :
                     (rsel == R_TABLE_POINTER_HIGH_REG)  ? {24'h000000, table_pointer_high_reg} :
                     (rsel == R_TABLE_HIGH_BYTE_REG)  ? {24'h000000, table_high_byte_reg} :
                     (rsel == R_PAGE)  ? {24'h000000, page} :
                     (rsel == R_EXEC)  ? {28'h0000000, cyc_q, skip_q, busy_o} :
                     (rsel == R_DMEM)  ? {24'h000000, dmem[s_axi_araddr_i[9:2]]} :
                                         32'h00000000;

    // ***************************************************************
    // sequencer
    // ***************************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:   next_state = start ? ST_EXEC : ST_IDLE;
            ST_EXEC:   next_state = is_tab ? ST_TFETCH : (skip_take ? ST_DUMMY : ST_IDLE);
            ST_TFETCH: next_state = ST_IDLE;
            ST_DUMMY:  next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state   <= ST_IDLE;
            busy_o  <= 1'b0;
            skip_o  <= 1'b0;
            skip_q  <= 1'b0;
            cyc_q   <= 2'h0;
            op_q    <= OP_SUB_MEM;
            bit_q   <= 3'h0;
            maddr_q <= RST_BYTE;
            lit_q   <= RST_BYTE;
        end else begin
            state  <= next_state;
            busy_o <= (next_state != ST_IDLE);
            skip_o <= skip_take;
            if (start) begin
                op_q    <= sst_op_t'(wdata_q[INSTR_OP_LSB +: 4]);
                bit_q   <= wdata_q[INSTR_BIT_LSB +: 3];
                maddr_q <= wdata_q[INSTR_ADR_LSB +: 8];
                lit_q   <= wdata_q[INSTR_LIT_LSB +: 8];
            end
            if (in_exec) begin
                skip_q <= skip_take;
                cyc_q  <= (skip_take | is_tab) ? CYC_TWO : CYC_ONE;
            end
        end
    end

    // ***************************************************************
    // architectural registers
    // ***************************************************************
    always_ff @(posedge clk_i) begin
        if (dmem_we) begin
            dmem[dmem_waddr] <= dmem_wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            acc   <= RST_BYTE;
            flags <= RST_FLAGS;
            table_pointer_low_reg  <= RST_BYTE;
            table_pointer_high_reg  <= RST_BYTE;
            table_high_byte_reg  <= RST_BYTE;
            page  <= RST_BYTE;
        end else begin
            if (acc_we) begin
                acc <= acc_wdata;
            end
            if (in_exec & is_sub) begin
                flags <= {sub_ov, is_zero(sub_res), sub_ac, sub_c};
            end else if (in_exec & is_xor) begin
                flags[FLAG_Z] <= is_zero(xor_res);
            end else if (wr_lane0 & (wsel == R_FLAGS)) begin
                flags <= wdata_q[3:0];
            end
            if (wr_lane0 & (wsel == R_TABLE_POINTER_LOW_REG)) begin
                table_pointer_low_reg <= wdata_q[7:0];
            end
            if (wr_lane0 & (wsel == R_TABLE_POINTER_HIGH_REG)) begin
                table_pointer_high_reg <= wdata_q[7:0];
            end
            if (wr_lane0 & (wsel == R_PAGE)) begin
                page <= wdata_q[7:0];
            end
            if (in_fetch) begin
                table_high_byte_reg <= prog_data_i[15:8];
            end
        end
    end

    // program memory is read in the same cycle the address leaves this flop
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prog_addr_o <= '0;
            prog_rd_o   <= 1'b0;
        end else begin
            prog_rd_o <= in_exec & is_tab;
            if (in_exec & is_tab) begin
                prog_addr_o <= tab_addr;
            end
        end
    end

    // ***************************************************************
    // AXI4-Lite handshakes
    // ***************************************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            aw_full         <= 1'b0;
            w_full          <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
            awaddr_q        <= 12'h000;
            wdata_q         <= 32'h00000000;
            wstrb_q         <= 4'h0;
        end else begin
            aw_full         <= next_aw_full;
            w_full          <= next_w_full;
            s_axi_awready_o <= ~next_aw_full;
            s_axi_wready_o  <= ~next_w_full;
            if (s_axi_awvalid_i & s_axi_awready_o) begin
                awaddr_q <= s_axi_awaddr_i[11:0];
            end
            if (s_axi_wvalid_i & s_axi_wready_o) begin
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= (wsel == R_NONE) ? RESP_SLVER : RESP_OKAY;
            end else if (b_done) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h00000000;
            s_axi_rresp_o   <= RESP_OKAY;
        end else begin
            s_axi_arready_o <= ~next_r_busy;
            s_axi_rvalid_o  <= next_r_busy;
            if (s_axi_arvalid_i & s_axi_arready_o) begin
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= (rsel == R_NONE) ? RESP_SLVER : RESP_OKAY;
            end
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_SUBTRACT_TO_MEMORY_OP_RESULT: assert property (
        (in_exec && op_q == OP_SUB_MEM) |=>
            dmem[$past(maddr_q)] == 8'($past(acc) - $past(mem_val)))
        else $error("subtract-to-memory stored a wrong difference");
    AST_CARRY_NOT_BORROW: assert property (
        (in_exec && is_sub) |=> flags[FLAG_C] == ($past(acc) >= $past(sub_b)))
        else $error("carry does not match not-borrow");
    AST_SUBI_ACC: assert property (
        (in_exec && op_q == OP_SUB_IMM) |=> acc == 8'($past(acc) - $past(lit_q)))
        else $error("subtract-immediate left a wrong accumulator");
    AST_SWAP_FLAGS: assert property (
        (in_exec && op_q == OP_SWAP_MEM) |=>
            flags == $past(flags) && dmem[$past(maddr_q)] == {$past(mem_val[3:0]),
                                                              $past(mem_val[7:4])})
        else $error("in-place swap wrong or touched flags");
    AST_NIBBLE_EXCHANGE_TO_ACC_OP_KEEP: assert property (
        (in_exec && op_q == OP_SWAP_ACC) |=>
            dmem[$past(maddr_q)] == $past(mem_val) &&
            acc == {$past(mem_val[3:0]), $past(mem_val[7:4])})
        else $error("swap-to-accumulator changed memory or acc");
    AST_SKIP_TWO_CYCLES: assert property (
        (in_exec && skip_take) |=> (state == ST_DUMMY && skip_o && busy_o) ##1 state == ST_IDLE)
        else $error("taken skip is not followed by exactly one dummy cycle");
    AST_ZERO_SKIP: assert property (
        (in_exec && op_q == OP_SKIP_ZERO) |-> skip_take == (mem_val == 8'h00))
        else $error("byte zero test skip decision wrong");
    AST_COPY_SKIP: assert property (
        (in_exec && op_q == OP_COPY_SKIP) |=>
            acc == $past(mem_val) && skip_q == ($past(mem_val) == 8'h00) && $stable(flags))
        else $error("copy-and-test wrong");
    AST_BIT_SKIP: assert property (
        (in_exec && op_q == OP_SKIP_BIT) |=> skip_q == !$past(mem_val[bit_q]))
        else $error("bit zero test skip decision wrong");
    AST_TAB_PAGED_ADDR: assert property (
        (in_exec && op_q == OP_TAB_PAGED) |=>
            prog_rd_o && prog_addr_o == {$past(table_pointer_high_reg[PW-1:0]), $past(table_pointer_low_reg)})
        else $error("paged table address wrong");
    AST_TAB_LAST_ADDR: assert property (
        (in_exec && op_q == OP_TAB_LAST) |=> prog_addr_o[PROG_AW-1:8] == {PW{1'b1}})
        else $error("last-page table address wrong");
    AST_TAB_SPLIT: assert property (
        in_fetch |=> table_high_byte_reg == $past(prog_data_i[15:8]) &&
                     dmem[$past(maddr_q)] == $past(prog_data_i[7:0]) && $stable(flags))
        else $error("table word split wrong");
    AST_XOR_ZERO_ONLY: assert property (
        (in_exec && is_xor) |=> flags[FLAG_Z] == ($past(xor_res) == 8'h00) &&
                                flags[1:0] == $past(flags[1:0]) &&
                                flags[FLAG_OV] == $past(flags[FLAG_OV]))
        else $error("xor touched flags other than zero");

    COV_SKIP_TAKEN:  cover property (in_exec && skip_take ##1 state == ST_DUMMY);
    COV_TABLE_READ:  cover property (in_exec && is_tab ##1 in_fetch ##1 state == ST_IDLE);
    COV_SUB_BORROW:  cover property (in_exec && is_sub && !sub_c);
    COV_XOR_MEM_ZERO: cover property (in_exec && op_q == OP_XOR_MEM && xor_res == 8'h00);

endmodule

// file: dv/sst_prog_model.sv
// program memory model for table reads
module sst_prog_model (
    input  wire logic        clk_i,
    input  wire logic [11:0] addr_i,
    input  wire logic        rd_i,
    output logic      [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last = 16'h0000;
    // stale cycles show a toggling word so an early or late capture is caught
    always_ff @(posedge clk_i) last <= ~data_o;
    // the word answers the registered address while the read strobe stands
    assign data_o = rd_i ? {4'hC, addr_i} : last;
endmodule

// file: dv/test_mcu_subtract_swap_skip_table_xor_ops.sv
// register-level bench for the subtract/swap/skip/table/xor core
module test_mcu_subtract_swap_skip_table_xor_ops import sst_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic        awr, wrd, bv, arr, rv, prd, busy, skip, sk;
    logic [11:0] awa = 0, ara = 0, pa;
    logic [31:0] wd = 0, rdat, got;
    logic [15:0] pd;
    logic [1:0]  br, rr, rsp, bsp;
    logic [7:0]  hi[3] = '{8'hCA, 8'hC3, 8'hCF};
    logic [3:0]  so[5] = '{4'h4, 4'h4, 4'h5, 4'h6, 4'h6};
    logic [2:0]  sb[5] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h0};
    logic [7:0]  sa[5] = '{8'h06, 8'h05, 8'h06, 8'h05, 8'h05};
    logic        se[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int          error_cnt = 0, checks_done = 0, n;
    initial forever #4 clk = ~clk;
    sst_core i_dut (.clk_i(clk), .resetn_i(rstn), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(FULL_STRB),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rre), .prog_addr_o(pa), .prog_rd_o(prd), .prog_data_i(pd),
        .busy_o(busy), .skip_o(skip));
    sst_prog_model i_prog (.clk_i(clk), .addr_i(pa), .rd_i(prd), .data_o(pd));
    // ****
    // bus and check tasks
    // ****
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo();
        if (n >= 40) begin
            chk("timeout", 0, 1);
            print_verdict();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        n = 0;
        awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
        do begin
            @(posedge clk);
            n++;
            if (awr === 1'b1) awv <= 0;
            if (wrd === 1'b1) wv <= 0;
        end while (bv !== 1'b1 && n < 40);
        bre <= 0;
        bsp = br;
        tmo();
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        n = 0;
        ara <= a; arv <= 1; rre <= 1;
        do begin
            @(posedge clk);
            n++;
            if (arr === 1'b1) arv <= 0;
        end while (rv !== 1'b1 && n < 40);
        rre <= 0; got = rdat; rsp = rr;
        tmo();
        chk(nm, {24'h0, e}, got);
    endtask
    // waits for idle and notes whether a dummy skip cycle was seen
    task automatic ex(input logic [3:0] op, input logic [2:0] b, input logic [7:0] m,
                      input logic [7:0] x);
        wr(ADDR_INSTR, {x, m, 5'h0, b, 4'h0, op});
        sk = 0; n = 0;
        do begin
            @(posedge clk);
            n++;
            sk |= (skip === 1'b1);
        end while (busy !== 1'b0 && n < 40);
        tmo();
    endtask
    function automatic logic [11:0] dm(input logic [7:0] m);
        return {DMEM_TAG, m, 2'h0};
    endfunction
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        wr(dm(5), 32'h30); wr(ADDR_ACC, 32'h20); ex(0, 0, 5, 0);
        rc("submem", dm(5), 8'hF0);
        rc("subflg", ADDR_FLAGS, 8'h02);
        wr(ADDR_ACC, 32'h80); ex(1, 0, 0, 8'h01);
        rc("subimm", ADDR_ACC, 8'h7F);
        rc("ovflg", ADDR_FLAGS, 8'h09);
        ex(1, 0, 0, 8'h7F); ex(2, 0, 5, 0);
        rc("swapm", dm(5), 8'h0F);
        ex(3, 0, 5, 0);
        rc("nibble_exchange_to_acc_op", ADDR_ACC, 8'hF0);
        rc("swapk", dm(5), 8'h0F);
        rc("swflg", ADDR_FLAGS, 8'h07);
        $display("test subtract swap done");
        wr(dm(6), 0);
        for (int i = 0; i < 5; i++) begin
            ex(so[i], sb[i], sa[i], 0);
            chk("skip", {31'h0, se[i]}, {31'h0, sk});
            rc("exec", ADDR_EXEC, se[i] ? 8'h0A : 8'h04);
        end
        rc("copy", ADDR_ACC, 8'h00);
        rc("skflg", ADDR_FLAGS, 8'h07);
        $display("test skip done");
        wr(ADDR_TABLE_POINTER_HIGH_REG, 32'hA); wr(ADDR_TABLE_POINTER_LOW_REG, 32'h34); wr(ADDR_PAGE, 32'h3);
        chk("wrresp", {30'h0, RESP_OKAY}, {30'h0, bsp});
        for (int i = 0; i < 3; i++) begin
            ex(4'h7 + i[3:0], 0, 8'h10, 0);
            rc("tblo", dm(8'h10), 8'h34);
            rc("tbhi", ADDR_TABLE_HIGH_BYTE_REG, hi[i]);
        end
        wr(ADDR_TABLE_HIGH_BYTE_REG, 32'h11);
        rc("tblhro", ADDR_TABLE_HIGH_BYTE_REG, 8'hCF);
        ex(12, 0, 0, 8'h5A);
        rc("xiflg", ADDR_FLAGS, 8'h03);
        ex(11, 0, 5, 0);
        rc("xmem", dm(5), 8'h55);
        ex(10, 0, 5, 0);
        rc("xacc", ADDR_ACC, 8'h0F);
        ex(12, 0, 0, 8'h0F);
        rc("xzflg", ADDR_FLAGS, 8'h07);
        chk("rdresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        rc("unmap", 12'h020, 8'h00);
        chk("unmresp", {30'h0, RESP_SLVER}, {30'h0, rsp});
        wr(12'h020, 32'h1);
        chk("unmwresp", {30'h0, RESP_SLVER}, {30'h0, bsp});
        $display("test table xor done");
        print_verdict();
    end
endmodule
